/* hdl/led_matrix_breath_control.sv */
// Purpose: Scan, PWM, breathing, open/short detect, interrupt, sync.
// Assumes: Register requests arrive as one-cycle strobes from the host
//          interface; sense inputs are synchronous.
// Notes: LED index is column * 4 + row.
`timescale 1ns/1ns
`include "led_matrix_consts.svh"
module led_matrix_breath_control #(
    parameter int FINE_CYC = `BREATH_FINE_CYC,
    parameter int DETECT_CYC = `DETECT_WAIT_CYC,
    parameter int SLOT_CYC = `SCAN_SLOT_CYC,
    parameter int AUTOCLR_CYC = `AUTOCLR_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input led_matrix_pkg::reg_req_t req,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic shutdown_n_pin,
    output logic int_n_pin,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic analog_on,
    // Matrix
    input wire logic [11:0] open_sense,
    input wire logic [11:0] short_sense,
    output led_matrix_pkg::matrix_t matrix
);
    import led_matrix_pkg::*;

    if (FINE_CYC < 1 || DETECT_CYC < 1 || SLOT_CYC < 1 ||
        AUTOCLR_CYC < 1 || FINE_CYC > 24'hffffff ||
        DETECT_CYC > 24'hffffff || SLOT_CYC > 24'hffffff ||
        AUTOCLR_CYC > 24'hffffff) begin : bad_param
        $error("Timing parameter out of range");
    end

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] global_current_level;
        logic [11:0][7:0] shadow;
        logic [11:0][7:0] act;
        logic [7:0] pullsel;
        logic [7:0] pdsel;
        logic [7:0] mask;
        logic [4:0] status;
        logic int_low;
        logic int_n;
        logic [23:0] ac_cnt;
        logic [11:0] onoff;
        logic [11:0][9:0] pwm;
        logic [11:0][1:0] sel;
        logic [11:0] opn;
        logic [11:0] sht;
        logic osd_q;
        logic det_busy;
        logic [23:0] det_cnt;
        logic [23:0] fine_cnt;
        phase_t [2:0] ph;
        logic [2:0][15:0] cnt;
        logic [2:0][7:0] loops;
        logic [2:0] stopped;
        logic [1:0] col;
        logic [23:0] slot_cnt;
        logic [9:0] pwm_cnt;
        logic sync_q;
        logic [7:0] rdata;
        logic sync_o;
        logic sync_en;
        logic ana;
        matrix_t mx;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    function automatic logic [15:0] ramp_dur(input logic [3:0] c);
        logic [3:0] k;
        k = (c > 4'h7) ? 4'h7 : c;
        return 16'h0080 << k;
    endfunction : ramp_dur

    function automatic logic [15:0] gap_dur(input logic [3:0] c);
        logic [3:0] k;
        k = (c > 4'h8) ? 4'h8 : c;
        return (c == 4'h0) ? 16'h0000 : (16'h0080 << (k - 4'h1));
    endfunction : gap_dur

    function automatic phase_t next_ph(input phase_t p);
        unique case (p)
            RISE_PHASE: return HOLD_PHASE;
            HOLD_PHASE: return FALL_PHASE;
            FALL_PHASE: return OFF_PHASE;
            default: return RISE_PHASE;
        endcase
    endfunction : next_ph

    function automatic phase_t code_ph(input logic [1:0] c);
        unique case (c)
            2'h0: return RISE_PHASE;
            2'h1: return HOLD_PHASE;
            2'h2: return FALL_PHASE;
            default: return OFF_PHASE;
        endcase
    endfunction : code_ph

    always_comb begin
        logic [4:0] ev;
        logic [4:0] ev_m;
        logic [2:0][9:0] lvl;
        logic [15:0] dur;
        logic [3:0] k;
        logic [7:0] lim;
        logic [6:0] ramp;
        logic fine_tick;
        logic cur_en;
        logic release_int;
        logic [9:0] bright;
        logic [11:0] drive;
        logic [1:0] sync_mode;
        logic sync_edge;
        int led;
        ev = 5'h00;
        ev_m = 5'h00;
        lvl = '0;
        dur = 16'h0000;
        k = 4'h0;
        lim = 8'h00;
        ramp = 7'h00;
        bright = 10'h000;
        drive = 12'h000;
        led = 0;
        fine_tick = 1'b0;
        cur_en = 1'b0;
        release_int = 1'b0;
        sync_edge = 1'b0;
        s_nxt = s_r;
        sync_mode = s_r.cfg[`CFG_SYNC_HI:`CFG_SYNC_LO];

        // Register writes; no mode gates them, so shutdown keeps all data
        if (req.wr) begin
            unique case (req.page)
                `PG_ONOFF: begin
                    if (req.addr == `A_ONOFF_LO) s_nxt.onoff[7:0] = req.wdata;
                    if (req.addr == `A_ONOFF_HI)
                        s_nxt.onoff[11:8] = req.wdata[3:0];
                end
                `PG_PWM: begin
                    if (req.addr < 8'h18) begin
                        led = int'(req.addr[7:1]);
                        if (req.addr[0]) s_nxt.pwm[led][9:8] = req.wdata[1:0];
                        else s_nxt.pwm[led][7:0] = req.wdata;
                    end
                end
                `PG_SELECT: begin
                    if (req.addr < 8'h0c)
                        s_nxt.sel[req.addr[3:0]] = req.wdata[1:0];
                end
                default: begin
                    if (req.addr == `A_CONFIG) s_nxt.cfg = req.wdata;
                    if (req.addr == `A_GCC) s_nxt.global_current_level = req.wdata;
                    if (req.addr >= `A_PROF_FIRST && req.addr <= `A_PROF_LAST)
                        s_nxt.shadow[req.addr[3:0] - 4'h2] = req.wdata;
                    if (req.addr == `A_PULLUP) s_nxt.pullsel = req.wdata;
                    if (req.addr == `A_PULLDOWN) s_nxt.pdsel = req.wdata;
                end
            endcase
            if (req.addr == `A_INT_MASK) s_nxt.mask = req.wdata;
        end

        // Update strobe loads the profiles and restarts each one that a fine tick in the same cycle does not step
        if (req.wr && req.page == `PG_FUNC && req.addr == `A_UPDATE) begin
            s_nxt.act = s_r.shadow;
            for (int p = 0; p < 3; p++) begin
                s_nxt.ph[p] = code_ph(s_r.shadow[4 * p + 2][5:4]);
                s_nxt.cnt[p] = 16'h0000;
                s_nxt.loops[p] = 8'h00;
                s_nxt.stopped[p] = 1'b0;
            end
        end

        // Breathing engine: one fine step is 1/128 of the shortest ramp
        fine_tick = (s_r.fine_cnt == 24'(FINE_CYC - 1));
        s_nxt.fine_cnt = fine_tick ? 24'h000000 : s_r.fine_cnt + 24'h000001;
        for (int p = 0; p < 3; p++) begin
            unique case (s_r.ph[p])
                RISE_PHASE: begin
                    k = s_r.act[4 * p][3:0];
                    dur = ramp_dur(k);
                end
                HOLD_PHASE: dur = gap_dur(s_r.act[4 * p][7:4]);
                FALL_PHASE: begin
                    k = s_r.act[4 * p + 1][3:0];
                    dur = ramp_dur(k);
                end
                default: dur = gap_dur(s_r.act[4 * p + 1][7:4]);
            endcase
            if (k > 4'h7) k = 4'h7;
            ramp = 7'(s_r.cnt[p] >> k);
            unique case (s_r.ph[p])
                RISE_PHASE: lvl[p] = {ramp, 3'h0};
                HOLD_PHASE: lvl[p] = 10'h3f8;
                FALL_PHASE: lvl[p] = {7'h7f - ramp, 3'h0};
                default: lvl[p] = 10'h000;
            endcase
            lim = (s_r.act[4 * p + 3] > `LOOP_MAX) ? `LOOP_MAX
                                                   : s_r.act[4 * p + 3];
            if (fine_tick && !s_r.stopped[p] && s_r.cfg[`CFG_BEN]) begin
                if (s_r.cnt[p] + 16'h0001 >= dur) begin
                    s_nxt.cnt[p] = 16'h0000;
                    if (s_r.ph[p] == (s_r.act[4 * p + 2][0] ? HOLD_PHASE
                                                            : OFF_PHASE)) begin
                        s_nxt.loops[p] = s_r.loops[p] + 8'h01;
                        // Count 0 is endless and never finishes
                        if (lim != 8'h00 &&
                            s_r.loops[p] + 8'h01 >= lim) begin
                            s_nxt.stopped[p] = 1'b1;
                            s_nxt.cnt[p] = s_r.cnt[p];
                            ev[`ST_PROF + p] = 1'b1;
                        end else begin
                            s_nxt.ph[p] = next_ph(s_r.ph[p]);
                        end
                    end else begin
                        s_nxt.ph[p] = next_ph(s_r.ph[p]);
                    end
                end else begin
                    s_nxt.cnt[p] = s_r.cnt[p] + 16'h0001;
                end
            end
        end

        // Open/short detection, one shot per rising trigger
        s_nxt.osd_q = s_r.cfg[`CFG_OSD];
        if (s_r.cfg[`CFG_OSD] && !s_r.osd_q) begin
            s_nxt.det_busy = 1'b1;
            s_nxt.det_cnt = 24'h000000;
        end else if (s_r.det_busy) begin
            s_nxt.det_cnt = s_r.det_cnt + 24'h000001;
            if (s_r.det_cnt == 24'(DETECT_CYC - 1)) begin
                s_nxt.det_busy = 1'b0;
                // Dark LEDs cannot be judged, so their bits stay as they were
                s_nxt.opn = (s_r.opn & ~s_r.onoff) |
                            (open_sense & s_r.onoff);
                s_nxt.sht = (s_r.sht & ~s_r.onoff) |
                            (short_sense & s_r.onoff);
                ev[`ST_OPEN] = |(open_sense & s_r.onoff);
                ev[`ST_SHORT] = |(short_sense & s_r.onoff);
            end
        end

        // Interrupt: a new event wins over a release in the same cycle
        ev_m = ev & s_r.mask[4:0];
        release_int = s_r.int_low &&
            ((req.rd && req.addr == `A_INT_STATUS) ||
             (s_r.mask[`MASK_IAC] &&
              s_r.ac_cnt == 24'(AUTOCLR_CYC - 1)));
        if (s_r.int_low) s_nxt.ac_cnt = s_r.ac_cnt + 24'h000001;
        if (ev_m != 5'h00) begin
            s_nxt.int_low = 1'b1;
            s_nxt.status = s_r.status | ev_m;
            s_nxt.ac_cnt = 24'h000000;
        end else if (release_int) begin
            s_nxt.int_low = 1'b0;
            s_nxt.status = 5'h00;
            s_nxt.ac_cnt = 24'h000000;
        end
        // Pin level is registered so the output comes straight from a flop
        s_nxt.int_n = !s_nxt.int_low;

        // Register reads
        if (req.rd) begin
            s_nxt.rdata = 8'h00;
            if (req.addr == `A_INT_STATUS) s_nxt.rdata = {3'h0, s_r.status};
            else if (req.addr == `A_INT_MASK) s_nxt.rdata = s_r.mask;
            else begin
                unique case (req.page)
                    `PG_ONOFF: begin
                        unique case (req.addr)
                            `A_ONOFF_LO: s_nxt.rdata = s_r.onoff[7:0];
                            `A_ONOFF_HI: s_nxt.rdata = {4'h0, s_r.onoff[11:8]};
                            `A_OPEN_LO: s_nxt.rdata = s_r.opn[7:0];
                            `A_OPEN_HI: s_nxt.rdata = {4'h0, s_r.opn[11:8]};
                            `A_SHORT_LO: s_nxt.rdata = s_r.sht[7:0];
                            `A_SHORT_HI: s_nxt.rdata = {4'h0, s_r.sht[11:8]};
                            default: s_nxt.rdata = 8'h00;
                        endcase
                    end
                    `PG_PWM: begin
                        if (req.addr < 8'h18) begin
                            led = int'(req.addr[7:1]);
                            s_nxt.rdata = req.addr[0]
                                ? {6'h00, s_r.pwm[led][9:8]}
                                : s_r.pwm[led][7:0];
                        end
                    end
                    `PG_SELECT: begin
                        if (req.addr < 8'h0c)
                            s_nxt.rdata = {6'h00, s_r.sel[req.addr[3:0]]};
                    end
                    default: begin
                        if (req.addr == `A_CONFIG) s_nxt.rdata = s_r.cfg;
                        if (req.addr == `A_GCC) s_nxt.rdata = s_r.global_current_level;
                        if (req.addr >= `A_PROF_FIRST &&
                            req.addr <= `A_PROF_LAST)
                            s_nxt.rdata = s_r.shadow[req.addr[3:0] - 4'h2];
                        if (req.addr == `A_PULLUP) s_nxt.rdata = s_r.pullsel;
                        if (req.addr == `A_PULLDOWN) s_nxt.rdata = s_r.pdsel;
                    end
                endcase
            end
        end

        // Scan timing; a slave restarts its frame on the master's edge
        s_nxt.sync_q = sync_in;
        sync_edge = (sync_mode == `SYNC_SLAVE) && sync_in && !s_r.sync_q;
        s_nxt.pwm_cnt = s_r.pwm_cnt + 10'h001;
        if (sync_edge) begin
            s_nxt.slot_cnt = 24'h000000;
            s_nxt.col = 2'h0;
        end else if (s_r.slot_cnt == 24'(SLOT_CYC - 1)) begin
            s_nxt.slot_cnt = 24'h000000;
            s_nxt.col = (s_r.col == 2'h2) ? 2'h0 : s_r.col + 2'h1;
        end else begin
            s_nxt.slot_cnt = s_r.slot_cnt + 24'h000001;
        end
        s_nxt.sync_en = (sync_mode == `SYNC_MASTER);
        s_nxt.sync_o = (sync_mode == `SYNC_MASTER) &&
                       (s_r.col == 2'h0);

        // Drive; brightness compare against a free 10-bit ramp
        cur_en = s_r.cfg[`CFG_SSD] && shutdown_n_pin;
        s_nxt.ana = shutdown_n_pin;
        for (int i = 0; i < 12; i++) begin
            if (!s_r.cfg[`CFG_BEN] || s_r.sel[i] == 2'h0)
                bright = s_r.pwm[i];
            else
                bright = lvl[int'(s_r.sel[i]) - 1];
            drive[i] = cur_en && s_r.onoff[i] &&
                       (s_r.pwm_cnt < bright) && (i / 4 == int'(s_r.col));
        end
        for (int c = 0; c < 3; c++) begin
            s_nxt.mx.column_switch_output[c] = cur_en &&
                                               (int'(s_r.col) == c);
            s_nxt.mx.col_pullup_on[c] = (s_r.pullsel != 8'h00) &&
                !(cur_en && int'(s_r.col) == c);
        end
        for (int r = 0; r < 4; r++) begin
            s_nxt.mx.row_current_output[r] = drive[r] || drive[r + 4] ||
                                             drive[r + 8];
            s_nxt.mx.row_pulldown_on[r] = (s_r.pdsel != 8'h00) &&
                !(drive[r] || drive[r + 4] || drive[r + 8]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.cfg <= `CFG_RESET;
            s_r.ph <= '{RISE_PHASE, RISE_PHASE, RISE_PHASE};
            s_r.int_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign int_n_pin = s_r.int_n;
    assign sync_out = s_r.sync_o;
    assign sync_oe = s_r.sync_en;
    assign analog_on = s_r.ana;
    assign matrix = s_r.mx;
endmodule : led_matrix_breath_control

/* inc/led_matrix_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 100 MHz clock, 8-bit registers on four pages.
// Notes: Times are kept in ns; cycle counts derive from them.
`ifndef LED_MATRIX_CONSTS_SVH
`define LED_MATRIX_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define BREATH_MIN_NS 210000000
`define BREATH_STEPS 128
`define BREATH_FINE_CYC (`BREATH_MIN_NS / `CLK_PERIOD_NS / `BREATH_STEPS)
`define DETECT_WAIT_NS 3264000
`define DETECT_WAIT_CYC (`DETECT_WAIT_NS / `CLK_PERIOD_NS)
`define SCAN_NS 1632000
`define SCAN_SLOT_CYC (`SCAN_NS / `CLK_PERIOD_NS / 3)
`define AUTOCLR_NS 8000000
`define AUTOCLR_CYC (`AUTOCLR_NS / `CLK_PERIOD_NS)
`define LOOP_MAX 8'hd4
`define PG_ONOFF 2'h0
`define PG_PWM 2'h1
`define PG_SELECT 2'h2
`define PG_FUNC 2'h3
`define A_ONOFF_LO 8'h00
`define A_ONOFF_HI 8'h01
`define A_OPEN_LO 8'h18
`define A_OPEN_HI 8'h19
`define A_SHORT_LO 8'h30
`define A_SHORT_HI 8'h31
`define A_CONFIG 8'h00
`define A_GCC 8'h01
`define A_PROF_FIRST 8'h02
`define A_PROF_LAST 8'h0d
`define A_UPDATE 8'h0e
`define A_PULLUP 8'h0f
`define A_PULLDOWN 8'h10
`define A_INT_MASK 8'hf0
`define A_INT_STATUS 8'hf1
`define CFG_SSD 0
`define CFG_BEN 1
`define CFG_OSD 2
`define CFG_SYNC_HI 7
`define CFG_SYNC_LO 6
`define SYNC_MASTER 2'h1
`define SYNC_SLAVE 2'h2
`define ST_OPEN 0
`define ST_SHORT 1
`define ST_PROF 2
`define MASK_IAC 7
`define CFG_RESET 8'h00
`endif

/* inc/led_matrix_pkg.sv */
// Purpose: Types shared by the matrix control logic.
// Assumes: Twelve LEDs in three columns of four rows.
// Notes: Phase codes are one-hot.
package led_matrix_pkg;
    typedef enum logic [3:0] {
        RISE_PHASE = 4'b0001,
        HOLD_PHASE = 4'b0010,
        FALL_PHASE = 4'b0100,
        OFF_PHASE = 4'b1000
    } phase_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [2:0] column_switch_output;
        logic [3:0] row_current_output;
        logic [2:0] col_pullup_on;
        logic [3:0] row_pulldown_on;
    } matrix_t;
endpackage : led_matrix_pkg

/* verif/led_matrix_breath_control_tb.sv */
// Purpose: Register-level tests of the matrix control logic.
// Assumes: Short parameter values keep breathing and detection brief.
// Notes: Scan-level PWM duty is left to longer runs.
`timescale 1ns/1ns
module led_matrix_breath_control_tb;
    import led_matrix_pkg::*;
    localparam int DET = 10;
    localparam int ACLR = 30;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic shutdown_n_pin = 1'b1;
    logic sync_in = 1'b0;
    logic [11:0] open_sense = 12'h000;
    logic [11:0] short_sense = 12'h000;
    logic [1:0] sm [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    reg_req_t req;
    logic [7:0] reg_rdata, d;
    logic int_n_pin, sync_out, sync_oe, analog_on;
    matrix_t matrix;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int hi = 0;
    int lit = 0;
    always #5 clk = ~clk;
    led_matrix_breath_control #(.FINE_CYC(2), .DETECT_CYC(DET),
        .SLOT_CYC(20), .AUTOCLR_CYC(ACLR)) dut_u (.clk(clk), .rst(rst),
        .req(req), .reg_rdata(reg_rdata), .shutdown_n_pin(shutdown_n_pin),
        .int_n_pin(int_n_pin), .sync_in(sync_in), .sync_out(sync_out),
        .sync_oe(sync_oe), .analog_on(analog_on), .open_sense(open_sense),
        .short_sense(short_sense), .matrix(matrix));
    led_matrix_host host_u (.clk(clk), .req(req), .reg_rdata(reg_rdata));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [1:0] pg, input logic [7:0] a, exp);
        host_u.rd(pg, a, d);
        chk(d, exp);
    endtask : rchk
    // Trigger is cleared first so each run sees a fresh rising edge
    task automatic detect(input logic [11:0] o, input logic [7:0] m);
        open_sense = o;
        short_sense = ~o;
        host_u.wr(2'h3, 8'hf0, m);
        host_u.wr(2'h3, 8'h00, 8'h01);
        host_u.wr(2'h3, 8'h00, 8'h05);
        repeat (DET + 6) @(negedge clk);
    endtask : detect
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rchk(2'h3, 8'h00, 8'h00);
        chk({7'h0, sync_oe}, 8'h00);
        rchk(2'h3, 8'hf1, 8'h00);
        host_u.wr(2'h3, 8'h0f, 8'h05);
        host_u.wr(2'h3, 8'h10, 8'h03);
        host_u.wr(2'h3, 8'h20, 8'h5a);
        rchk(2'h3, 8'h0f, 8'h05);
        rchk(2'h3, 8'h20, 8'h00);
        foreach (sm[i]) begin
            host_u.wr(2'h3, 8'h00, {sm[i], 6'h01});
            repeat (3) @(negedge clk);
            chk({7'h0, sync_oe}, {7'h0, sm[i] == 2'h1});
            hi = 0;
            repeat (60) begin
                @(negedge clk);
                hi += sync_out;
            end
            // Master shows column 0 for 20 of every 60 cycles
            chk(8'(hi), (sm[i] == 2'h1) ? 8'h14 : 8'h00);
        end
        $display("test registers and sync done");
        host_u.wr(2'h3, 8'h01, 8'h01);
        host_u.wr(2'h0, 8'h00, 8'hff);
        detect(12'hfa5, 8'h03);
        chk({7'h0, int_n_pin}, 8'h00);
        rchk(2'h0, 8'h18, 8'ha5);
        rchk(2'h0, 8'h19, 8'h00);
        rchk(2'h0, 8'h30, 8'h5a);
        rchk(2'h0, 8'h31, 8'h00);
        rchk(2'h1, 8'hf1, 8'h03);
        chk({7'h0, int_n_pin}, 8'h01);
        rchk(2'h3, 8'hf1, 8'h00);
        open_sense = 12'h00f;
        host_u.wr(2'h3, 8'h00, 8'h05);
        repeat (DET + 6) @(negedge clk);
        rchk(2'h0, 8'h18, 8'ha5);
        chk({7'h0, int_n_pin}, 8'h01);
        detect(12'h00f, 8'h00);
        chk({7'h0, int_n_pin}, 8'h01);
        rchk(2'h3, 8'hf1, 8'h00);
        rchk(2'h0, 8'h18, 8'h0f);
        detect(12'h00f, 8'h81);
        chk({7'h0, int_n_pin}, 8'h00);
        repeat (ACLR + 4) @(negedge clk);
        chk({7'h0, int_n_pin}, 8'h01);
        rchk(2'h3, 8'hf1, 8'h00);
        $display("test detection and interrupt done");
        shutdown_n_pin = 1'b0;
        host_u.wr(2'h3, 8'h0f, 8'h07);
        chk({7'h0, analog_on}, 8'h00);
        rchk(2'h3, 8'h0f, 8'h07);
        shutdown_n_pin = 1'b1;
        host_u.wr(2'h3, 8'h00, 8'h00);
        rchk(2'h3, 8'h10, 8'h03);
        rchk(2'h0, 8'h18, 8'h0f);
        $display("test shutdown done");
        // Profile one: shortest ramps, single loop, stop at off phase
        host_u.wr(2'h3, 8'h05, 8'h01);
        host_u.wr(2'h2, 8'h00, 8'h01);
        host_u.wr(2'h3, 8'hf0, 8'h04);
        host_u.wr(2'h1, 8'h00, 8'hff);
        host_u.wr(2'h1, 8'h01, 8'h03);
        host_u.wr(2'h3, 8'h00, 8'h01);
        lit = 0;
        repeat (1200) begin
            @(negedge clk);
            lit += matrix.row_current_output[0];
        end
        // Selector 01 with breathing off still drives direct PWM
        chk({7'h0, lit > 390}, 8'h01);
        chk({7'h0, int_n_pin}, 8'h01);
        host_u.wr(2'h3, 8'h00, 8'h03);
        repeat (1200) @(negedge clk);
        chk({7'h0, int_n_pin}, 8'h01);
        host_u.wr(2'h3, 8'h0e, 8'h00);
        for (int i = 0; i < 2000 && int_n_pin !== 1'b0; i++) @(negedge clk);
        chk({7'h0, int_n_pin}, 8'h00);
        rchk(2'h2, 8'hf1, 8'h04);
        $display("test breathing done");
        close_out();
    end
endmodule : led_matrix_breath_control_tb

/* verif/led_matrix_chk.sv */
// Purpose: Port-level checks of the matrix control logic.
// Assumes: Config and mask shadows follow host writes at the same edge.
// Notes: Settling windows of two cycles cover registered outputs.
`timescale 1ns/1ns
module led_matrix_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input led_matrix_pkg::reg_req_t req,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic shutdown_n_pin,
    input wire logic int_n_pin,
    input wire logic sync_oe,
    input wire logic analog_on,
    // Matrix
    input led_matrix_pkg::matrix_t matrix
);
    import led_matrix_pkg::*;
    logic [7:0] cfg_r;
    logic [7:0] mask_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= 8'h00;
            mask_r <= 8'h00;
        end else if (req.wr) begin
            if (req.page == 2'h3 && req.addr == 8'h00) cfg_r <= req.wdata;
            if (req.addr == 8'hf0) mask_r <= req.wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Outputs derived from config need it steady first
    sequence cfg_held;
        cfg_r == $past(cfg_r) && $past(cfg_r) == $past(cfg_r, 2);
    endsequence
    sequence status_read;
        req.rd && req.addr == 8'hf1;
    endsequence
    a_sync_drive: assert property (cfg_held |->
        sync_oe == (cfg_r[7:6] == 2'h1)) else $error("sync drive wrong");
    a_soft_blank: assert property (cfg_held ##0 !cfg_r[0] |->
        matrix.row_current_output == 4'h0) else $error("matrix not blank");
    a_pullup_off: assert property (
        (matrix.col_pullup_on & matrix.column_switch_output) == 3'h0)
        else $error("pull-up on active column");
    a_pulldown_off: assert property (
        (matrix.row_pulldown_on & matrix.row_current_output) == 4'h0)
        else $error("pull-down on active row");
    a_int_masked: assert property ($fell(int_n_pin) |->
        $past(mask_r[4:0]) != 5'h00) else $error("interrupt while masked");
    a_int_release: assert property (!$past(rst) && $rose(int_n_pin) |->
        $past(req.rd && req.addr == 8'hf1) || $past(mask_r[7]))
        else $error("interrupt released without cause");
    a_status_idle: assert property (status_read ##0 int_n_pin |=>
        reg_rdata == 8'h00) else $error("status set while pin high");
    a_analog_follow: assert property (!$past(rst) |->
        analog_on == $past(shutdown_n_pin)) else $error("analog enable wrong");
endmodule : led_matrix_chk
bind led_matrix_breath_control led_matrix_chk chk_u (.clk(clk), .rst(rst),
    .req(req), .reg_rdata(reg_rdata), .shutdown_n_pin(shutdown_n_pin),
    .int_n_pin(int_n_pin), .sync_oe(sync_oe), .analog_on(analog_on),
    .matrix(matrix));

/* verif/led_matrix_host.sv */
// Purpose: Host controller model issuing register strobes.
// Assumes: One-cycle strobes, read data valid one cycle later.
// Notes: Drives at falling edges so the block samples settled values.
`timescale 1ns/1ns
module led_matrix_host (
    // Clock
    input wire logic clk,
    // Register access
    output led_matrix_pkg::reg_req_t req,
    input wire logic [7:0] reg_rdata
);
    import led_matrix_pkg::*;
    initial req = '0;
    task automatic wr(input logic [1:0] pg, input logic [7:0] a, dat);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: dat};
        @(negedge clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [1:0] pg, input logic [7:0] a,
                      output logic [7:0] dat);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 8'h00};
        @(negedge clk);
        req <= '0;
        @(negedge clk);
        dat = reg_rdata;
    endtask : rd
endmodule : led_matrix_host
